// ==== src/acm_map.svh ====
/*
 * Register map, field positions, reset values and bus constants of the
 * comparator event control block.
 * Assumes a 32-bit classic Wishbone slave port with byte addressing.
 */
// Operation
// - Raw result high when positive input exceeds negative
// - Result bit synchronised, lags one to two cycles
// - Disable bit seven powers comparator off
// - Bandgap bit six picks reference over pin
// - Chosen transition sets event flag bit four
// - Entering interrupt vector clears event flag
// - Writing one clears flag, zero keeps it
// - Request needs flag, enable bit three, global enable
// - Mode 00 toggle, 01 reserved, 10 fall, 11 rise
// - Capture route bit two feeds timer capture
// - Route bit zero isolates comparator from capture
`ifndef ACM_MAP_SVH
`define ACM_MAP_SVH

//==========================================================
// Register offsets (byte addresses on the bus)
`define ACM_OFS_CSR       6'h00
`define ACM_OFS_ISR       6'h04
`define ACM_OFS_IMR       6'h08
`define ACM_ADDR_W        6

//==========================================================
// Control/status register field positions
`define ACM_BIT_OFF       7
`define ACM_BIT_BG        6
`define ACM_BIT_RES       5
`define ACM_BIT_FLAG      4
`define ACM_BIT_IEN       3
`define ACM_BIT_ROUTE     2
`define ACM_BIT_MODE_HI   1
`define ACM_BIT_MODE_LO   0

//==========================================================
// Interrupt status / mask register field positions
`define ACM_IRQ_EVENT     0
`define ACM_IRQ_CHANGE    1
`define ACM_IRQ_W         2

//==========================================================
// Reset values
`define ACM_CSR_RESET     8'h00
`define ACM_IRQ_RESET     2'h0
`define ACM_DATA_ZERO     32'h00000000
`define ACM_PAD_ZERO      24'h000000
`define ACM_PAD_IRQ       30'h00000000

`endif

// ==== src/acm_pkg.sv ====
/*
 * Types of the comparator event control block: event modes and the
 * packed bus carriers.
 * Assumes acm_map.svh supplies the numeric constants.
 */
package acm_pkg;

	//==========================================================
	// Event mode field encoding
	typedef enum logic [1:0] {
		ACM_MODE_TOGGLE = 2'h0,
		ACM_MODE_RSVD   = 2'h1,
		ACM_MODE_FALL   = 2'h2,
		ACM_MODE_RISE   = 2'h3
	} acm_mode_t;

	//==========================================================
	// Classic Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [5:0]  adr;
		logic [31:0] dat;
	} acm_wb_req_t;

	// Classic Wishbone answer to the master
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} acm_wb_rsp_t;

	// Analog side controls driven by the block
	typedef struct packed {
		logic off;
		logic bg_sel;
	} acm_ana_t;

endpackage

// ==== src/acm_sync.sv ====
/*
 * Two flip-flop level synchroniser for the raw comparator output.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module acm_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Level in and out
	input  wire logic d,
	output var  logic q
);

	logic meta_reg;

	//==========================================================
	// Only the second stage reads the first; nothing else may
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// ==== src/acm_ctrl.sv ====
/*
 * Comparator event control: control/status register, result
 * synchroniser, edge detection, event flag, interrupt request and
 * routing of the result to the timer capture front end, with a
 * classic Wishbone register port and a masked interrupt output.
 * Assumes the analog comparator, the timer capture logic and the
 * processor's vector logic all sit outside; all but the raw result
 * run on clk.
 */
`timescale 1ns/1ps
`default_nettype none

`include "acm_map.svh"

module acm_ctrl (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// Wishbone slave port
	input  wire acm_pkg::acm_wb_req_t wb_req,
	output var  acm_pkg::acm_wb_rsp_t wb_rsp,
	// Analog comparator
	input  wire logic                 cmp_raw,
	output var  acm_pkg::acm_ana_t    ana_ctl,
	// Processor interrupt handshake
	input  wire logic                 global_irq_en,
	input  wire logic                 irq_vec_taken,
	output var  logic                 cmp_irq_req,
	// Timer capture front end
	output var  logic                 capture_in,
	// Masked status interrupt
	output var  logic                 irq
);

	import acm_pkg::*;

	//==========================================================
	// State of the block
	typedef struct packed {
		logic                  off;
		logic                  bg_sel;
		logic                  flag;
		logic                  ien;
		logic                  route;
		acm_mode_t             mode;
		logic                  prev;
		logic                  cap;
		logic                  req;
		logic [`ACM_IRQ_W-1:0] isr;
		logic [`ACM_IRQ_W-1:0] imr;
		logic                  irq;
		logic                  ack;
		logic [31:0]           rdat;
	} acm_state_t;

	acm_state_t st_reg;
	acm_state_t st_next;
	logic       res_sync;

	//==========================================================
	// Functions

	// True when the sample pair shows the edge the mode asks for
	function automatic logic edge_hit(input acm_mode_t m,
	                                  input logic      p,
	                                  input logic      c);
		logic hit;
		hit = 1'b0;
		case (m)
			ACM_MODE_TOGGLE: hit = p ^ c;
			ACM_MODE_FALL:   hit = p & ~c;
			ACM_MODE_RISE:   hit = ~p & c;
			ACM_MODE_RSVD:   hit = 1'b0;
			default:         hit = 1'b0;
		endcase
		return hit;
	endfunction

	// True when the address selects the given register offset
	function automatic logic adr_is(input logic [5:0] a,
	                                input logic [5:0] ofs);
		return a == ofs;
	endfunction

	//==========================================================
	// Result synchroniser; the raw input is high while the
	// positive input exceeds the negative one
	acm_sync u_sync (
		.clk   (clk),
		.reset (reset),
		.d     (cmp_raw),
		.q     (res_sync)
	);

	//==========================================================
	// Next state
	always_comb begin
		logic       access;
		logic       wr_ok;
		logic       wr_csr;
		logic       wr_imr;
		logic       rd_isr;
		logic       hit;
		logic       chg;
		logic [7:0] csr_view;
		logic [7:0] wbyte;

		st_next  = st_reg;
		access   = wb_req.cyc & wb_req.stb & ~st_reg.ack;
		// Writes land at the edge where the master samples ack,
		// so a master that aborts before ack changes nothing
		wr_ok    = wb_req.cyc & wb_req.stb & wb_req.we & st_reg.ack;
		wr_csr   = wr_ok & wb_req.sel[0] &
		           adr_is(wb_req.adr, `ACM_OFS_CSR);
		wr_imr   = wr_ok & wb_req.sel[0] &
		           adr_is(wb_req.adr, `ACM_OFS_IMR);
		rd_isr   = access & ~wb_req.we &
		           adr_is(wb_req.adr, `ACM_OFS_ISR);
		wbyte    = wb_req.dat[7:0];

		// Edge seen between the previous and current sample
		hit      = edge_hit(st_reg.mode, st_reg.prev, res_sync);
		chg      = st_reg.prev ^ res_sync;

		// Register image as software reads it
		csr_view = {st_reg.off, st_reg.bg_sel, res_sync,
		            st_reg.flag, st_reg.ien, st_reg.route,
		            st_reg.mode};

		// Sample history for edge detection
		st_next.prev = res_sync;

		// Control bits; software may flip the disable bit at will
		if (wr_csr) begin
			st_next.off    = wbyte[`ACM_BIT_OFF];
			st_next.bg_sel = wbyte[`ACM_BIT_BG];
			st_next.ien    = wbyte[`ACM_BIT_IEN];
			st_next.route  = wbyte[`ACM_BIT_ROUTE];
			st_next.mode   = acm_mode_t'({wbyte[`ACM_BIT_MODE_HI],
			                              wbyte[`ACM_BIT_MODE_LO]});
		end

		// Event flag: clears first, a new event wins over them
		if (wr_csr && wbyte[`ACM_BIT_FLAG]) begin
			st_next.flag = 1'b0;
		end
		if (irq_vec_taken) begin
			st_next.flag = 1'b0;
		end
		if (hit) begin
			st_next.flag = 1'b1;
		end

		// Request to the processor needs all three conditions
		st_next.req = st_next.flag & st_next.ien & global_irq_en;

		// Capture path is forced low unless routed
		st_next.cap = st_reg.route ? res_sync : 1'b0;

		// Sticky status: read clears, a same-cycle event survives
		if (rd_isr) begin
			st_next.isr = `ACM_IRQ_RESET;
		end
		if (hit) begin
			st_next.isr[`ACM_IRQ_EVENT] = 1'b1;
		end
		if (chg) begin
			st_next.isr[`ACM_IRQ_CHANGE] = 1'b1;
		end
		if (wr_imr) begin
			st_next.imr = wbyte[`ACM_IRQ_W-1:0];
		end
		st_next.irq = |(st_next.isr & st_next.imr);

		// Bus answer: one ack per request, dropped the next cycle
		st_next.ack = access;
		if (access && !wb_req.we) begin
			if (adr_is(wb_req.adr, `ACM_OFS_CSR)) begin
				st_next.rdat = {`ACM_PAD_ZERO, csr_view};
			end else if (adr_is(wb_req.adr, `ACM_OFS_ISR)) begin
				st_next.rdat = {`ACM_PAD_IRQ, st_reg.isr};
			end else if (adr_is(wb_req.adr, `ACM_OFS_IMR)) begin
				st_next.rdat = {`ACM_PAD_IRQ, st_reg.imr};
			end else begin
				st_next.rdat = `ACM_DATA_ZERO;
			end
		end else begin
			st_next.rdat = `ACM_DATA_ZERO;
		end
	end

	//==========================================================
	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg.off    <= 1'b0;
			st_reg.bg_sel <= 1'b0;
			st_reg.flag   <= 1'b0;
			st_reg.ien    <= 1'b0;
			st_reg.route  <= 1'b0;
			st_reg.mode   <= ACM_MODE_TOGGLE;
			st_reg.prev   <= 1'b0;
			st_reg.cap    <= 1'b0;
			st_reg.req    <= 1'b0;
			st_reg.isr    <= `ACM_IRQ_RESET;
			st_reg.imr    <= `ACM_IRQ_RESET;
			st_reg.irq    <= 1'b0;
			st_reg.ack    <= 1'b0;
			st_reg.rdat   <= `ACM_DATA_ZERO;
		end else begin
			st_reg <= st_next;
		end
	end

	//==========================================================
	// Outputs, all straight from the state register
	assign wb_rsp.ack     = st_reg.ack;
	assign wb_rsp.dat     = st_reg.rdat;
	assign ana_ctl.off    = st_reg.off;
	assign ana_ctl.bg_sel = st_reg.bg_sel;
	assign cmp_irq_req    = st_reg.req;
	assign capture_in     = st_reg.cap;
	assign irq            = st_reg.irq;

endmodule

`default_nettype wire

// ==== test/acm_ctrl_sva.sv ====
/* Port checker of the comparator event block.
   Assumes it is bound to acm_ctrl and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// Checker
module acm_ctrl_sva (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 reset,
	// Bus
	input wire acm_pkg::acm_wb_req_t wb_req,
	input wire acm_pkg::acm_wb_rsp_t wb_rsp,
	// Analog and processor side
	input wire logic                 cmp_raw,
	input wire acm_pkg::acm_ana_t    ana_ctl,
	input wire logic                 global_irq_en,
	input wire logic                 irq_vec_taken,
	input wire logic                 cmp_irq_req,
	input wire logic                 capture_in,
	input wire logic                 irq
);
	import acm_pkg::*;
	logic       last_reg;
	logic [2:0] calm_reg;
	// Cycles since the raw result moved, saturating at seven
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			last_reg <= 1'h0;
			calm_reg <= 3'h0;
		end else begin
			last_reg <= cmp_raw;
			calm_reg <= (cmp_raw != last_reg) ? 3'h0 :
				calm_reg + {2'h0, calm_reg != 3'h7};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence req_s; wb_req.cyc && wb_req.stb && !wb_rsp.ack; endsequence
	sequence ans_s; wb_rsp.ack ##1 !wb_rsp.ack; endsequence
	bus_answer_a: assert property (req_s |=> ans_s)
		else $error("bus answer missing or long");
	rdata_idle_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
		else $error("read data outside ack");
	rdata_pad_a: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0)
		else $error("upper read bits set");
	ana_hold_a: assert property (!$past(wb_rsp.ack) |-> $stable(ana_ctl))
		else $error("analog control moved without write");
	capture_lag_a: assert property (capture_in |-> $past(cmp_raw, 3))
		else $error("capture path not from result");
	req_gie_a: assert property (!$past(global_irq_en) |-> !cmp_irq_req)
		else $error("request without global enable");
	vec_clear_a: assert property
		(irq_vec_taken && calm_reg >= 3'h4 |=> !cmp_irq_req)
		else $error("vector entry left request up");
	irq_cause_a: assert property
		($rose(irq) |-> wb_rsp.ack || $past(wb_rsp.ack) || calm_reg < 3'h5)
		else $error("interrupt with no cause");
endmodule

bind acm_ctrl acm_ctrl_sva chk (.clk(clk), .reset(reset), .wb_req(wb_req),
	.wb_rsp(wb_rsp), .cmp_raw(cmp_raw), .ana_ctl(ana_ctl),
	.global_irq_en(global_irq_en), .irq_vec_taken(irq_vec_taken),
	.cmp_irq_req(cmp_irq_req), .capture_in(capture_in), .irq(irq));
`default_nettype wire

// ==== test/acm_cmp_model.sv ====
/* Behavioural analog comparator facing the block.
   Assumes pin voltages arrive as level codes from the bench. */
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// Comparator model
module acm_cmp_model #(
	parameter logic [7:0] BG_LVL = 8'h80
) (
	// Clock and reset of the timer side
	input  wire logic              clk,
	input  wire logic              reset,
	// Controls from the block
	input  wire acm_pkg::acm_ana_t ana_ctl,
	// Pin levels
	input  wire logic [7:0]        pos_lvl,
	input  wire logic [7:0]        neg_lvl,
	// Raw result
	output logic                   cmp_raw,
	// Timer capture front end
	input  wire logic              capture_in,
	input  wire logic              cap_mask,
	output logic [3:0]             cap_count
);
	import acm_pkg::*;
	logic [7:0] plus_lvl;
	logic       cap_prev;
	// Capture interrupts count rising edges, only while unmasked
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cap_prev  <= 1'h0;
			cap_count <= 4'h0;
		end else begin
			cap_prev <= capture_in;
			if (cap_mask && capture_in && !cap_prev) begin
				cap_count <= cap_count + 4'h1;
			end
		end
	end
	// Bandgap replaces the pin on the plus side
	assign plus_lvl = ana_ctl.bg_sel ? BG_LVL : pos_lvl;
	// Powered off it sits low, so a toggle mode may see an edge
	assign cmp_raw = !ana_ctl.off && (plus_lvl > neg_lvl);
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
/* Self-checking bench of the comparator event block.
   Assumes the comparator model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// Bench top
module tb_top;
	import acm_pkg::*;
	logic        clk, reset, global_irq_en, irq_vec_taken;
	logic        cmp_raw, cmp_irq_req, capture_in, irq;
	logic [7:0]  pos_lvl, neg_lvl;
	logic        cap_mask;
	logic [3:0]  cap_count;
	logic [31:0] q;
	acm_wb_req_t wb_req;
	acm_wb_rsp_t wb_rsp;
	acm_ana_t    ana_ctl;
	int          err_count, checks;

	acm_ctrl dut (.clk(clk), .reset(reset), .wb_req(wb_req),
		.wb_rsp(wb_rsp), .cmp_raw(cmp_raw), .ana_ctl(ana_ctl),
		.global_irq_en(global_irq_en), .irq_vec_taken(irq_vec_taken),
		.cmp_irq_req(cmp_irq_req), .capture_in(capture_in), .irq(irq));
	acm_cmp_model cmp (.clk(clk), .reset(reset), .ana_ctl(ana_ctl),
		.pos_lvl(pos_lvl), .neg_lvl(neg_lvl), .cmp_raw(cmp_raw),
		.capture_in(capture_in), .cap_mask(cap_mask),
		.cap_count(cap_count));

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Classic cycle; the idle edge at the end keeps requests apart
	task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] d);
		wb_req <= '{1'h1, 1'h1, we, 4'hF, a, {24'h0, d}};
		// Waits for ack; only the bench timeout ends this wait if ack never comes
		do begin
			@(posedge clk);
		end while (wb_rsp.ack !== 1'h1);
		q = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clk);
	endtask
	task automatic t_reset();
		for (int a = 0; a < 4; a++) begin
			wb(1'h0, 6'(a * 4), 8'h00);
			chk("reset value", 32'h0, q);
		end
	endtask
	task automatic t_analog();
		wb(1'h1, 6'h00, 8'hC0);
		chk("ana ctl", 32'h3, {30'h0, ana_ctl});
		wb(1'h1, 6'h00, 8'h40);
		tick(2);
		wb(1'h0, 6'h00, 8'h00);
		chk("bandgap csr", 32'h70, q);
		wb(1'h1, 6'h00, 8'h00);
		tick(5);
	endtask
	task automatic t_modes();
		logic [1:0] m;
		logic f;
		global_irq_en <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wb(1'h1, 6'h00, {6'h04, m});
			wb(1'h1, 6'h00, {6'h02, m});
			for (int e = 0; e < 2; e++) begin
				pos_lvl <= (e == 0) ? 8'hC0 : 8'h00;
				tick(5);
				f = (m == 2'h0) || (m == {1'h1, e == 0});
				chk("req", {31'h0, f}, {31'h0, cmp_irq_req});
				wb(1'h1, 6'h00, {6'h02, m});
				wb(1'h0, 6'h00, 8'h00);
				chk("flag", {26'h0, e == 0, f, 2'h2, m}, q);
				wb(1'h1, 6'h00, {6'h06, m});
				wb(1'h0, 6'h00, 8'h00);
				chk("cleared", {26'h0, e == 0, 3'h2, m}, q);
			end
		end
	endtask
	task automatic t_vec();
		wb(1'h1, 6'h00, 8'h13);
		wb(1'h1, 6'h00, 8'h0B);
		global_irq_en <= 1'h0;
		pos_lvl <= 8'hC0;
		tick(5);
		chk("gie off", 32'h0, {31'h0, cmp_irq_req});
		global_irq_en <= 1'h1;
		tick(2);
		chk("gie on", 32'h1, {31'h0, cmp_irq_req});
		irq_vec_taken <= 1'h1;
		tick(1);
		irq_vec_taken <= 1'h0;
		tick(2);
		chk("vec req", 32'h0, {31'h0, cmp_irq_req});
		wb(1'h0, 6'h00, 8'h00);
		chk("vec flag", 32'h2B, q);
		wb(1'h1, 6'h00, 8'h03);
	endtask
	task automatic t_route();
		cap_mask <= 1'h1;
		wb(1'h1, 6'h00, 8'h04);
		for (int e = 0; e < 3; e++) begin
			pos_lvl <= (e == 1) ? 8'h00 : 8'hC0;
			tick(4);
			chk("capture", {31'h0, e != 1}, {31'h0, capture_in});
		end
		wb(1'h1, 6'h00, 8'h10);
		tick(4);
		chk("no route", 32'h0, {31'h0, capture_in});
		chk("capture count", 32'h2, {28'h0, cap_count});
	endtask
	task automatic t_irq();
		wb(1'h0, 6'h04, 8'h00);
		wb(1'h1, 6'h08, 8'h01);
		pos_lvl <= 8'h00;
		tick(5);
		chk("irq set", 32'h1, {31'h0, irq});
		wb(1'h0, 6'h04, 8'h00);
		chk("status", 32'h3, q);
		chk("irq read", 32'h0, {31'h0, irq});
		wb(1'h1, 6'h08, 8'h00);
		pos_lvl <= 8'hC0;
		tick(5);
		chk("irq masked", 32'h0, {31'h0, irq});
		wb(1'h1, 6'h08, 8'h02);
		chk("irq unmask", 32'h1, {31'h0, irq});
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Clock and hang guard
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		tick(3000);
		err_count++;
		give_verdict();
	end
	// Main sequence
	initial begin
		reset = 1'h1;
		wb_req = '0;
		pos_lvl = 8'h00;
		neg_lvl = 8'h40;
		global_irq_en = 1'h0;
		irq_vec_taken = 1'h0;
		cap_mask = 1'h0;
		tick(2);
		reset <= 1'h0;
		tick(1);
		t_reset();
		t_analog();
		t_modes();
		t_vec();
		t_route();
		t_irq();
		give_verdict();
	end
endmodule
`default_nettype wire
